// [rtl/rcp_pkg.sv]
/*
 * Constants, register layout and carrier types for the serial register
 * command port. Assumes one system clock domain plus the serial clock.
 */
package rcp_pkg;

	// ---------------------------------------------------------------
	// Register pointers
	// ---------------------------------------------------------------
	localparam logic [3:0] PTR_GAIN = 4'h0;
	localparam logic [3:0] PTR_SRST = 4'h1;
	localparam logic [3:0] PTR_ERR = 4'h4;
	localparam logic [3:0] PTR_CSEN = 4'h9;
	localparam logic [3:0] PTR_ECFG = 4'ha;
	localparam logic [3:0] PTR_FCFG = 4'hb;
	localparam logic [3:0] PTR_LAST = 4'hc;
	localparam int NUM_REGS = 13;

	// ---------------------------------------------------------------
	// Reset values and writable bit masks
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_BUFFER_TIMEOUT_VALUE = 8'h19;
	localparam logic [7:0] RST_SWA = 8'h60;
	localparam logic [7:0] RST_FCFG = 8'h10;
	localparam logic [7:0] MSK_ALL = 8'hff;
	localparam logic [7:0] MSK_PIN7 = 8'h7f;
	localparam logic [7:0] MSK_BUFFER_TIMEOUT_VALUE = 8'h3f;
	localparam logic [7:0] MSK_SWB = 8'h0f;
	localparam logic [7:0] MSK_FCFG = 8'hbd;
	localparam logic [7:0] MSK_NONE = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int BIT_SRST = 0;
	localparam int BIT_CHKEN = 0;
	localparam int BIT_CHECKSUM_ERROR_FLAG = 7;
	localparam int BIT_BUFFER_ACTIVE_FLAG = 5;
	localparam int BIT_EF = 3;
	localparam logic [7:0] ERR_STICKY = 8'hd7;
	localparam logic [7:0] ERR_AMP = 8'h57;

	// ---------------------------------------------------------------
	// Command byte layout
	// ---------------------------------------------------------------
	localparam logic [1:0] OP_WRITE = 2'b01;
	localparam logic [1:0] OP_DIRECT = 2'b11;
	localparam logic [3:0] OP_READ = 4'b1000;
	localparam int BIT_TRIG = 5;
	localparam int BIT_ZERO = 4;
	localparam int BIT_CSZERO = 3;
	localparam logic [2:0] CS_PIN_MAX = 3'h6;
	localparam int NUM_PINS = 7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [7:0] CHK_SEED = 8'h9b;
	localparam logic [7:0] TEST_VALUE = 8'h00; // Arbitrary test readback

	// Serial state
	typedef enum logic [2:0] {
		PH_CMD = 3'b000,
		PH_DATA = 3'b001,
		PH_CHK = 3'b010,
		PH_PAD = 3'b011,
		PH_IGN = 3'b100
	} rcp_phase_e;

	// Configuration carried out to the analog and pin logic
	typedef struct packed {
		logic [7:0] gain_mux;
		logic [7:0] clk_pol;
		logic [7:0] buf_timeout;
		logic [7:0] pin_data;
		logic [7:0] switch_a;
		logic [7:0] switch_b;
		logic [7:0] pin_dir;
		logic [7:0] pin_cs_en;
		logic [7:0] err_cfg;
		logic [7:0] flag_cfg;
		logic [7:0] special_fn;
	} rcp_cfg_s;

endpackage

// [rtl/rcp_spi_regport.sv]
/*
 * Serial register command port: shift logic on the serial clock, register
 * bank on the system clock. Assumes the host respects the serial rate
 * limit so that held write words are stable long before they are used.
 * The system reset is applied while select is high and the clock idle.
 */
`timescale 1ns/100ps
module rcp_spi_regport
	import rcp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n, // Select, active low; slave only
	input wire logic sdi,
	output logic sdo_o,
	output logic sdo_oe,
	output logic [NUM_PINS-1:0] ext_cs_n,
	input wire logic [4:0] amp_err_in,
	input wire logic buffer_active_in,
	output logic buffer_start,
	output rcp_cfg_s cfg
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [7:0] chk(input logic [7:0] a,
		input logic [7:0] b);
		chk = a + b + CHK_SEED;
	endfunction

	function automatic logic [7:0] rst_value(input logic [3:0] p);
		unique case (p)
			4'h3: rst_value = RST_BUFFER_TIMEOUT_VALUE;
			4'h6: rst_value = RST_SWA;
			PTR_FCFG: rst_value = RST_FCFG;
			default: rst_value = RST_ZERO;
		endcase
	endfunction

	// Only assigned bits accept data
	function automatic logic [7:0] wr_mask(input logic [3:0] p);
		unique case (p)
			PTR_GAIN, PTR_ECFG, PTR_LAST: wr_mask = MSK_ALL;
			4'h2, 4'h5, 4'h6, 4'h8, PTR_CSEN: wr_mask = MSK_PIN7;
			4'h3: wr_mask = MSK_BUFFER_TIMEOUT_VALUE;
			4'h7: wr_mask = MSK_SWB;
			PTR_FCFG: wr_mask = MSK_FCFG;
			default: wr_mask = MSK_NONE;
		endcase
	endfunction

	// Redirect target must exist and have its select mode enabled
	function automatic logic pin_ok(input logic [2:0] c,
		input logic [7:0] en);
		pin_ok = (c <= CS_PIN_MAX) && en[c];
	endfunction

	// ---------------------------------------------------------------
	// Serial clock domain
	// ---------------------------------------------------------------
	// No system reset on the shift state: select high clears it, so a
	// cut frame leaves nothing behind. Only the event toggles and the held
	// write word keep their value from one frame to the next.
	rcp_phase_e phase_reg;
	logic [2:0] bit_cnt_reg;
	logic [6:0] rx_reg;
	logic [7:0] cmd_reg;
	logic [7:0] dat_reg;
	logic [7:0] tx_reg;
	logic [7:0] wr_ptr_dat_reg;
	logic [3:0] wr_ptr_reg;
	logic wr_tgl_reg;
	logic trg_tgl_reg;
	logic cer_tgl_reg;
	logic [7:0] snap_reg [0:15];
	logic [7:0] rx_byte;
	logic byte_done;
	logic chk_en;
	logic is_write;
	logic is_read;
	logic is_direct;
	logic cs_ok;
	logic write_now;
	logic direct_now;
	logic direct_chk;

	assign rx_byte = {rx_reg, sdi};
	assign byte_done = (bit_cnt_reg == BIT_LAST);
	// Quasi-static copy, only refreshed between frames or after writes
	assign chk_en = snap_reg[PTR_FCFG][BIT_CHKEN];
	assign is_write = (cmd_reg[7:6] == OP_WRITE) && !cmd_reg[BIT_ZERO];
	assign is_read = (cmd_reg[7:4] == OP_READ);
	assign is_direct = (cmd_reg[7:6] == OP_DIRECT) && !cmd_reg[BIT_ZERO];
	assign cs_ok = pin_ok(cmd_reg[2:0], snap_reg[PTR_CSEN]);

	// Bit counter; select high clears it, dropping partial bytes
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_reg <= 3'h0;
			rx_reg <= 7'h00;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			rx_reg <= rx_byte[6:0];
		end
	end

	// Command sequencer, one step per received byte
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			phase_reg <= PH_CMD;
			cmd_reg <= 8'h00;
			dat_reg <= 8'h00;
		end else if (byte_done) begin
			unique case (phase_reg)
				PH_CMD: begin
					cmd_reg <= rx_byte;
					if (rx_byte[7:4] == OP_READ) begin
						dat_reg <= snap_reg[rx_byte[3:0]];
						phase_reg <= PH_DATA;
					end else if (rx_byte[7:6] == OP_WRITE
						&& !rx_byte[BIT_ZERO]) begin
						phase_reg <= PH_DATA;
					end else if (rx_byte[7:6] == OP_DIRECT
						&& !rx_byte[BIT_ZERO] && !rx_byte[BIT_CSZERO]) begin
						// No data byte for the direct command
						phase_reg <= chk_en ? PH_CHK : PH_IGN;
					end else begin
						phase_reg <= PH_IGN; // Reserved codes
					end
				end
				PH_DATA: begin
					if (is_read) begin
						phase_reg <= PH_CHK;
					end else begin
						dat_reg <= rx_byte;
						phase_reg <= chk_en ? PH_CHK : PH_PAD;
					end
				end
				PH_CHK: begin
					if (is_direct && rx_byte == chk(cmd_reg, 8'h00)) begin
						phase_reg <= PH_IGN;
					end else begin
						phase_reg <= PH_CMD;
					end
				end
				PH_PAD: phase_reg <= PH_CMD;
				PH_IGN: phase_reg <= PH_IGN;
			endcase
		end
	end

	// Read shifter: data byte then checksum, MSB first
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			tx_reg <= 8'h00;
		end else if (byte_done && phase_reg == PH_CMD) begin
			tx_reg <= snap_reg[rx_byte[3:0]];
		end else if (byte_done && phase_reg == PH_DATA) begin
			tx_reg <= chk(cmd_reg, dat_reg);
		end else begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	// Floats unless a read is in its data or checksum byte
	// Data moves on falling edges; the host samples on rising ones
	assign sdo_o = tx_reg[7];
	assign sdo_oe = !cs_n && is_read
		&& (phase_reg == PH_DATA || phase_reg == PH_CHK);

	// ---------------------------------------------------------------
	// Command execution
	// ---------------------------------------------------------------
	// Write completes after its data byte, or after a good checksum
	assign write_now = is_write && ((phase_reg == PH_DATA && !chk_en)
		|| (phase_reg == PH_CHK && rx_byte == chk(cmd_reg, dat_reg)));
	// Direct command acts at once when no checksum byte follows
	assign direct_now = phase_reg == PH_CMD && !chk_en
		&& rx_byte[7:6] == OP_DIRECT && !rx_byte[BIT_ZERO]
		&& !rx_byte[BIT_CSZERO];
	assign direct_chk = phase_reg == PH_CHK && is_direct
		&& rx_byte == chk(cmd_reg, 8'h00);

	// Redirected select; select high releases it at once
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			ext_cs_n <= '1;
		end else if (byte_done && direct_now) begin
			if (pin_ok(rx_byte[2:0], snap_reg[PTR_CSEN])) begin
				ext_cs_n[rx_byte[2:0]] <= 1'b0;
			end
		end else if (byte_done && direct_chk && cs_ok) begin
			ext_cs_n[cmd_reg[2:0]] <= 1'b0;
		end
	end

	// Event toggles and held write word. Select high must not clear
	// them: the system side would see the drop as one more event. The
	// system reset clears them instead, while the serial clock is idle.
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			wr_ptr_reg <= 4'h0;
			wr_ptr_dat_reg <= 8'h00;
			wr_tgl_reg <= 1'b0;
			trg_tgl_reg <= 1'b0;
			cer_tgl_reg <= 1'b0;
		end else if (byte_done) begin
			if (write_now) begin
				wr_ptr_reg <= cmd_reg[3:0];
				wr_ptr_dat_reg <= (phase_reg == PH_DATA) ? rx_byte : dat_reg;
				wr_tgl_reg <= !wr_tgl_reg;
			end
			// Trigger bit of an executed write or direct command only
			if ((write_now && cmd_reg[BIT_TRIG])
				|| (direct_now && rx_byte[BIT_TRIG])
				|| (direct_chk && cmd_reg[BIT_TRIG])) begin
				trg_tgl_reg <= !trg_tgl_reg;
			end
			// Bad checksum on write or direct: drop and flag
			if (phase_reg == PH_CHK && !is_read
				&& rx_byte != chk(cmd_reg, is_write ? dat_reg : 8'h00)) begin
				cer_tgl_reg <= !cer_tgl_reg;
			end
		end
	end

	// ---------------------------------------------------------------
	// Crossings into the system clock
	// ---------------------------------------------------------------
	logic [3:0] sync1_reg;
	logic [3:0] sync2_reg;
	logic [2:0] sync3_reg;
	logic [4:0] err_s1_reg;
	logic [4:0] err_s2_reg;
	logic [2:0] evt;
	logic frame_idle;

	// Two stages for select level and event toggles
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= 4'h0;
			sync2_reg <= 4'h0;
			sync3_reg <= 3'h0;
			err_s1_reg <= 5'h00;
			err_s2_reg <= 5'h00;
		end else begin
			sync1_reg <= {cs_n, cer_tgl_reg, trg_tgl_reg, wr_tgl_reg};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg[2:0];
			err_s1_reg <= {amp_err_in[4:1], amp_err_in[0]};
			err_s2_reg <= err_s1_reg;
		end
	end

	logic buffer_active_flag_s1_reg;
	logic buffer_active_flag_s2_reg;

	// Buffer status level from the analog side
	always_ff @(posedge clk) begin
		if (rst) begin
			buffer_active_flag_s1_reg <= 1'b0;
			buffer_active_flag_s2_reg <= 1'b0;
		end else begin
			buffer_active_flag_s1_reg <= buffer_active_in;
			buffer_active_flag_s2_reg <= buffer_active_flag_s1_reg;
		end
	end

	// A toggle change seen past both stages marks one event; the held
	// write word settled long before, so it is read without stages
	assign evt = sync2_reg[2:0] ^ sync3_reg; // {chk err, trigger, write}
	assign frame_idle = sync2_reg[3];

	// ---------------------------------------------------------------
	// Register bank
	// ---------------------------------------------------------------
	logic [7:0] regs_reg [0:NUM_REGS-1];
	logic [7:0] err_reg;
	logic [7:0] err_set;
	logic [7:0] err_clr;
	logic [7:0] err_view;
	logic soft_rst;
	logic wr_ev;
	logic snap_upd_reg;

	// Soft reset is a one-cycle pulse; its bit is never stored
	assign wr_ev = evt[0];
	assign soft_rst = wr_ev && wr_ptr_reg == PTR_SRST
		&& wr_ptr_dat_reg[BIT_SRST];

	// Plain read/write registers; soft reset reloads defaults
	always_ff @(posedge clk) begin
		if (rst || soft_rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				regs_reg[i] <= rst_value(4'(i));
			end
		end else if (wr_ev && wr_ptr_reg <= PTR_LAST) begin
			// Unassigned, write-only and test bits keep their value
			regs_reg[wr_ptr_reg] <= (regs_reg[wr_ptr_reg]
				& ~wr_mask(wr_ptr_reg))
				| (wr_ptr_dat_reg & wr_mask(wr_ptr_reg));
		end
	end

	// Sticky errors: set beats a simultaneous write-one clear
	assign err_set = {evt[2], err_s2_reg[4], 1'b0, err_s2_reg[3], 1'b0,
		err_s2_reg[2:0]};
	assign err_clr = (wr_ev && wr_ptr_reg == PTR_ERR)
		? (wr_ptr_dat_reg & ERR_STICKY) : 8'h00;

	always_ff @(posedge clk) begin
		if (rst || soft_rst) begin
			err_reg <= RST_ZERO;
		end else begin
			err_reg <= (err_reg & ~err_clr) | err_set;
		end
	end

	// Error view adds buffer status and the masked combined flag
	always_comb begin
		err_view = err_reg;
		err_view[BIT_BUFFER_ACTIVE_FLAG] = buffer_active_flag_s2_reg;
		err_view[BIT_EF] = |(err_reg & ERR_AMP & ~regs_reg[PTR_ECFG]);
	end

	// Readback copy for the serial side; frozen during a frame so the
	// other clock never samples a word mid-change, except after writes
	always_ff @(posedge clk) begin
		if (rst) begin
			snap_upd_reg <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				snap_reg[i] <= rst_value(4'(i));
			end
		end else begin
			snap_upd_reg <= wr_ev;
			if (frame_idle || snap_upd_reg) begin
				for (int i = 0; i < 16; i++) begin
					if (i == PTR_SRST) begin
						snap_reg[i] <= RST_ZERO;
					end else if (i == PTR_ERR) begin
						snap_reg[i] <= err_view;
					end else if (i > PTR_LAST) begin
						snap_reg[i] <= TEST_VALUE;
					end else begin
						snap_reg[i] <= regs_reg[i];
					end
				end
			end
		end
	end

	// Buffer start pulse from the trigger bit
	always_ff @(posedge clk) begin
		if (rst) begin
			buffer_start <= 1'b0;
		end else begin
			buffer_start <= evt[1];
		end
	end

	// Configuration outputs straight from the register flops
	assign cfg = '{gain_mux: regs_reg[0], clk_pol: regs_reg[2],
		buf_timeout: regs_reg[3], pin_data: regs_reg[5],
		switch_a: regs_reg[6], switch_b: regs_reg[7],
		pin_dir: regs_reg[8], pin_cs_en: regs_reg[9],
		err_cfg: regs_reg[10], flag_cfg: regs_reg[11],
		special_fn: regs_reg[12]};

endmodule

// [verification/rcp_spi_regport_properties.sv]
/* Port checker: serial output timing, select routing, reset and masks.
   Bound into rcp_spi_regport; sees its ports only. */
`timescale 1ns/100ps
module rcp_spi_regport_properties
	import rcp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo_oe,
	input wire logic [NUM_PINS-1:0] ext_cs_n,
	input wire logic buffer_start,
	input rcp_cfg_s cfg
);
	// ---------------
	// Frame tracking
	// ---------------
	logic [7:0] n_edge;
	logic [7:0] cmd;
	// Select high restarts the count, just as it clears the port
	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			n_edge <= 8'h00;
		end else if (n_edge != 8'hff) begin
			n_edge <= n_edge + 8'h01;
		end
	end
	// First command only; chained commands are not tracked here
	always_ff @(negedge sclk) begin
		if (n_edge < 8'h08) begin
			cmd <= {cmd[6:0], sdi};
		end
	end
	sequence s_idle;
		cs_n [*3];
	endsequence
	sequence s_rd_data;
		n_edge >= 8'h08 && n_edge < 8'h18 && cmd[7:4] == OP_READ;
	endsequence
	// -----------
	// Assertions
	// -----------
	a_oe_idle: assert property (@(posedge sclk) disable iff (cs_n)
		n_edge >= 8'h08 && n_edge < 8'h18 && cmd[7:4] != OP_READ
		|-> !sdo_oe) else $error("sdo driven without a read");
	a_ecs_release: assert property (@(posedge clk) disable iff (rst)
		s_idle |-> &ext_cs_n) else $error("redirect held past select");
	a_ecs_single: assert property (@(posedge clk) disable iff (rst)
		$onehot0(~ext_cs_n)) else $error("two redirected selects");
	a_start_pulse: assert property (@(posedge clk) disable iff (rst)
		buffer_start |=> !buffer_start) else $error("trigger not a pulse");
	a_reset_defaults: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> cfg == 88'h0000190060000000001000 && !buffer_start)
		else $error("reset values wrong");
	a_mask_bits: assert property (@(posedge clk) disable iff (rst)
		(cfg.clk_pol & ~MSK_PIN7) == 8'h00 && (cfg.switch_b & ~MSK_SWB) == 8'h00
		&& (cfg.buf_timeout & ~MSK_BUFFER_TIMEOUT_VALUE) == 8'h00
		&& (cfg.flag_cfg & ~MSK_FCFG) == 8'h00) else $error("unused bit set");
	a_cmd_float: assert property (@(posedge sclk) disable iff (cs_n)
		n_edge < 8'h08 |-> !sdo_oe) else $error("sdo driven in command");
	a_read_drive: assert property (@(posedge sclk) disable iff (cs_n)
		s_rd_data |-> sdo_oe) else $error("read data not driven");
	a_direct_quiet: assert property (@(posedge sclk) disable iff (cs_n)
		n_edge >= 8'h08 && cmd[7:6] == OP_DIRECT |-> !sdo_oe)
		else $error("sdo driven while redirected");
endmodule
bind rcp_spi_regport rcp_spi_regport_properties i_props (.clk(clk),
	.rst(rst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_oe(sdo_oe),
	.ext_cs_n(ext_cs_n), .buffer_start(buffer_start), .cfg(cfg));

// [verification/rcp_host_model.sv]
/* Serial host model: frames bits on a 15 ns clock, either idle level.
   Assumes the bench calls xfer, one caller at a time. */
`timescale 1ns/100ps
module rcp_host_model (
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo_o,
	input wire logic sdo_oe
);
	logic sdo_line;
	// No pull on the data out wire: released means floating
	assign sdo_line = sdo_oe ? sdo_o : 1'bz;
	// Select starts low and rises once all processes wait on it, so
	// the serial state is cleared by a real edge
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		sdi = 1'b0;
		#1 cs_n = 1'b1;
	end
	// 15 ns bit period, above the host rate limit to stress crossings
	// Clock stands still outside frames; keep leaves select low
	task automatic xfer(input int nbits, input logic [63:0] tx,
		input logic hi, input logic keep, output logic [63:0] rx);
		rx = '0;
		if (cs_n) begin
			sclk = hi;
			#5 cs_n = 1'b0;
			#10;
		end
		for (int i = nbits - 1; i >= 0; i--) begin
			sdi = tx[i];
			#4 sclk = 1'b1;
			rx[i] = sdo_line;
			#7 sclk = 1'b0;
			#4 sclk = hi;
		end
		#5 sdi = ~sdi;
		if (!keep) begin
			cs_n = 1'b1;
			#30;
		end
	endtask
endmodule

// [verification/rcp_spi_regport_bench.sv]
/* Bench for the serial register port with a register model.
   Assumes the host model and the bound checker are compiled first. */
`timescale 1ns/100ps
module rcp_spi_regport_bench
	import rcp_pkg::*;
;
	logic clk, rst, sclk, cs_n, sdi, sdo_o, sdo_oe, buffer_active_in;
	logic buffer_start, chk_on;
	logic [NUM_PINS-1:0] ext_cs_n;
	logic [4:0] amp_err_in;
	rcp_cfg_s cfg;
	int n_fail, check_count, cyc, starts, exp_starts;
	logic [31:0] seed;
	logic [63:0] rx;
	logic [7:0] mdl [16];
	logic [7:0] errm;
	rcp_spi_regport i_dut (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
		.sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ext_cs_n(ext_cs_n),
		.amp_err_in(amp_err_in), .buffer_active_in(buffer_active_in),
		.buffer_start(buffer_start), .cfg(cfg));
	rcp_host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo_o(sdo_o), .sdo_oe(sdo_oe));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Cycle ceiling guards against a hung frame; counts trigger pulses
	always @(posedge clk) begin
		cyc++;
		if (buffer_start === 1'b1) starts++;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [7:0] msk(input logic [3:0] p);
		case (p)
			4'h2, 4'h5, 4'h6, 4'h8, 4'h9: return MSK_PIN7;
			4'h3: return MSK_BUFFER_TIMEOUT_VALUE;
			4'h7: return MSK_SWB;
			4'hb: return MSK_FCFG;
			4'h0, 4'ha, 4'hc: return MSK_ALL;
			default: return MSK_NONE;
		endcase
	endfunction
	task automatic check(input logic [127:0] seen, input logic [127:0] exp,
		input string what);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask
	task automatic give_verdict();
		if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Model defaults, shared by power-on and software reset
	task automatic mreset();
		foreach (mdl[i]) mdl[i] = 8'h00;
		mdl[3] = RST_BUFFER_TIMEOUT_VALUE;
		mdl[6] = RST_SWA;
		mdl[PTR_FCFG] = RST_FCFG;
		errm = 8'h00;
		chk_on = 1'b0;
	endtask
	task automatic chk_cfg();
		check(cfg, {mdl[0], mdl[2], mdl[3], mdl[5], mdl[6], mdl[7],
			mdl[8], mdl[9], mdl[10], mdl[11], mdl[12]}, "cfg");
	endtask
	// Write, with checksum when enabled; good low corrupts the sum
	task automatic wr(input logic [3:0] p, input logic [7:0] d,
		input logic t, input logic good);
		logic [7:0] c;
		logic [7:0] s;
		c = {OP_WRITE, t, 1'b0, p};
		s = c + d + CHK_SEED + {7'h00, !good};
		seed = xs(seed);
		if (chk_on) i_host.xfer(24, {40'h0, c, d, s}, seed[0], 1'b0, rx);
		else i_host.xfer(16, {48'h0, c, d}, seed[0], 1'b0, rx);
		repeat (8) @(posedge clk);
		if (good || !chk_on) begin
			if (t) exp_starts++;
			if (p == PTR_SRST && d[BIT_SRST]) mreset();
			else if (p == PTR_ERR) errm = errm & ~d;
			else mdl[p] = d & msk(p);
			if (p == PTR_FCFG) chk_on = d[BIT_CHKEN];
		end else errm[BIT_CHECKSUM_ERROR_FLAG] = 1'b1;
		chk_cfg();
		check(starts, exp_starts, "trigger");
	endtask
	task automatic rd(input logic [3:0] p);
		logic [7:0] e;
		e = (p != PTR_ERR) ? mdl[p] : {errm[7:6], buffer_active_in, errm[4],
			|(errm & ERR_AMP & ~mdl[PTR_ECFG]), errm[2:0]};
		seed = xs(seed);
		i_host.xfer(24, {40'h0, OP_READ, p, 16'h0}, seed[0], 1'b0, rx);
		check(rx[15:0], {e, 8'({OP_READ, p} + e + CHK_SEED)}, "read");
	endtask
	initial begin
		rst <= 1'b1;
		amp_err_in <= 5'h00;
		buffer_active_in <= 1'b0;
		seed = 32'h71e6;
		mreset();
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		// Defaults, then random values through the write masks
		for (int p = 0; p < 16; p++) rd(4'(p));
		for (int p = 0; p < 16; p++) begin
			seed = xs(seed);
			if (p != 1 && p != 4 && p != 11) wr(4'(p), seed[15:8], 1'b0, 1'b1);
		end
		for (int p = 0; p < 16; p++) rd(4'(p));
		// Error events with a live buffer flag, then clear by ones
		@(posedge clk);
		amp_err_in <= seed[20:16] | 5'h01;
		buffer_active_in <= 1'b1;
		repeat (4) @(posedge clk);
		errm = {1'b0, amp_err_in[4], 1'b0, amp_err_in[3], 1'b0, amp_err_in[2:0]};
		amp_err_in <= 5'h00;
		repeat (4) @(posedge clk);
		rd(PTR_ERR);
		wr(PTR_ERR, seed[31:24], 1'b0, 1'b1);
		rd(PTR_ERR);
		// Checksum mode: good, bad and cut-short writes, soft reset
		wr(PTR_FCFG, 8'hff, 1'b0, 1'b1);
		wr(PTR_GAIN, 8'h5a, 1'b1, 1'b1);
		wr(PTR_GAIN, 8'ha5, 1'b0, 1'b0);
		i_host.xfer(16, {48'h0, 8'h40, 8'h33}, 1'b0, 1'b0, rx);
		repeat (8) @(posedge clk);
		rd(PTR_GAIN);
		rd(PTR_ERR);
		wr(PTR_SRST, 8'h01, 1'b0, 1'b1);
		wr(PTR_GAIN, 8'h18, 1'b0, 1'b1);
		// Read chained with a write under one select
		i_host.xfer(48, {16'h0, 8'h83, 16'h0, 8'h40, 8'h3c, 8'h00}, 1'b1, 1'b0,
			rx);
		check(rx[39:24], {mdl[3], 8'(8'h83 + mdl[3] + CHK_SEED)}, "chain");
		mdl[0] = 8'h3c;
		repeat (8) @(posedge clk);
		chk_cfg();
		// Every redirect code; trailing write must be ignored
		wr(PTR_CSEN, {1'b0, seed[6:1], 1'b1}, 1'b0, 1'b1);
		for (int c = 0; c < 8; c++) begin
			i_host.xfer(8, {56'h0, OP_DIRECT, c == 0, 2'b00, 3'(c)}, 1'b1, 1'b1,
				rx);
			repeat (4) @(posedge clk);
			check(ext_cs_n, (c < 7 && mdl[9][c]) ? 7'(~(7'h01 << c)) : 7'h7f,
				"select");
			i_host.xfer(16, {48'h0, 8'h40, 8'hff}, 1'b1, 1'b0, rx);
			repeat (8) @(posedge clk);
			exp_starts += (c == 0);
			check(ext_cs_n, 7'h7f, "release");
			check(starts, exp_starts, "trigger");
			chk_cfg();
		end
		give_verdict();
	end
endmodule
